// ==== logic/flash_wp_defines.vh ====
// constants for the block write-protect logic
`ifndef FLASH_WP_DEFINES_VH
`define FLASH_WP_DEFINES_VH

// axi register byte offsets
`define ADDR_STATUS 4'h0
`define ADDR_CONFIG 4'h4
`define ADDR_RANGE 4'h8
`define ADDR_EVENTS 4'hc

// status register field positions
`define ST_WEL 1
`define ST_CODE_LSB 2
`define ST_CODE_MSB 5
`define ST_QUAD 6
`define ST_WR_DISABLE 7
// reset value of the stored bits 7..2
`define STATUS_RESET 6'h00

// config register field positions
`define CFG_BOTTOM 0
`define CFG_ALT 1
`define CONFIG_RESET 2'h0

// block number field of a 24-bit address
`define BLK_MSB 23
`define BLK_LSB 16

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// opcodes
`define OP_WR_ENABLE 8'h06
`define OP_SR_WRITE 8'h01
`define OP_VRP_NOWEL 8'hc0
`define OP_VBA_NOWEL 8'h17
`define OP_VRP_WEL 8'h63
`define OP_VBA_WEL 8'hc5
`define OP_PP 8'h02
`define OP_PP4 8'h12
`define OP_PPQ_A 8'h32
`define OP_PPQ_B 8'h38
`define OP_PPQ4_A 8'h34
`define OP_PPQ4_B 8'h3e
`define OP_SE_A 8'hd7
`define OP_SE_B 8'h20
`define OP_SE4 8'h21
`define OP_BE32 8'h52
`define OP_BE32_4 8'h5c
`define OP_BE64 8'hd8
`define OP_BE64_4 8'hdc
`define OP_CE_A 8'hc7
`define OP_CE_B 8'h60

`endif

// ==== logic/prot_range_decode.v ====
// protection code to protected block range decoder
`timescale 1ns/1ps
`default_nettype none
module prot_range_decode #(
   parameter BLK_W = 8
) (
   // code and selection
   input wire [3:0] code,
   input wire bottom,
   input wire alt_table,
   // decoded range, inclusive
   output reg [BLK_W-1:0] lo,
   output reg [BLK_W-1:0] hi,
   output reg none
);
   localparam [BLK_W:0] TOTAL = {1'b1, {BLK_W{1'b0}}};
   reg [BLK_W:0] count;
   reg [BLK_W:0] top_lo;
   reg [BLK_W:0] bot_hi;
   always @* begin
      count = {(BLK_W+1){1'b0}};
      if (code == 4'h0) begin
         count = {(BLK_W+1){1'b0}};
      end else if (code <= 4'h8) begin
         count = TOTAL >> (4'h9 - code); // see R11
      end else if (alt_table && code != 4'hf) begin
         count = TOTAL - (TOTAL >> (code - 4'h7)); // see R14
      end else begin
         count = TOTAL; // see R13
      end
      top_lo = TOTAL - count;
      bot_hi = count - {{BLK_W{1'b0}}, 1'b1};
      none = (code == 4'h0);
      if (bottom) begin
         lo = {BLK_W{1'b0}}; // see R12
         hi = bot_hi[BLK_W-1:0];
      end else begin
         lo = top_lo[BLK_W-1:0];
         hi = {BLK_W{1'b1}};
      end
   end
endmodule
`default_nettype wire

// ==== logic/flash_block_write_protect.v ====
// write-protect gate for program, erase and status-write commands
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "flash_wp_defines.vh"

// Notes on behaviour
// R1: opcodes c0h and 17h pass without the write-enable latch set.
// R2: program or erase into the protected block range is inhibited.
// R3: whole-chip erase ignored unless protection code is zero.
// R4: status write disable low lets status writes through regardless of pin.
// R5: disable high and protect pin low locks status bits; write ignored.
// R6: disable high and protect pin high lets status writes change status.
// R7: quad enable low gives protect and hold pins their control roles.
// R8: quad enable high turns both pins into quad data lines c and d.
// R9: host keeps quad enable low when those pins are tied to supply.
// R10: 256 blocks of 64 KB; code bit three most significant.
// R11: top, standard: code n protects 2^(n-1) blocks ending at 255.
// R12: bottom selection counts the same blocks upward from block 0.
// R13: standard table codes 9 to 15 protect all 256 blocks.
// R14: optional table codes 9..14 protect 192..254 blocks, 15 all.
// R15: top/bottom select bit, one-time set, anchors range at bottom.
// R16: host issues write enable 06h before commands needing the latch.
// R17: target block taken from address bits 23..16, compared to range.
module flash_block_write_protect #(
   parameter BLK_W = 8,
   parameter CNT_W = 8
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire awvalid,
   output reg awready,
   input wire [3:0] awaddr,
   input wire [2:0] awprot,
   // axi4-lite write data
   input wire wvalid,
   output reg wready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   // axi4-lite write response
   output reg bvalid,
   input wire bready,
   output reg [1:0] bresp,
   // axi4-lite read address
   input wire arvalid,
   output reg arready,
   input wire [3:0] araddr,
   input wire [2:0] arprot,
   // axi4-lite read data
   output reg rvalid,
   input wire rready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   // decoded command from the serial front end
   input wire cmd_valid,
   input wire [7:0] cmd_opcode,
   input wire [23:0] cmd_addr,
   input wire [7:0] cmd_status_data,
   // command verdict
   output reg cmd_done,
   output reg cmd_granted,
   output reg cmd_blocked,
   // protect pin / quad data line c
   input wire quad_data_line_c_in,
   output reg quad_data_line_c_out,
   output reg quad_data_line_c_oe,
   // hold-or-reset pin / quad data line d
   input wire quad_data_line_d_in,
   output reg quad_data_line_d_out,
   output reg quad_data_line_d_oe,
   // core side of the shared pins
   input wire core_c_out,
   input wire core_c_oe,
   input wire core_d_out,
   input wire core_d_oe,
   output reg core_c_in,
   output reg core_d_in,
   output reg hold_n,
   output reg quad_enable
);

   // status and config state
   reg [7:2] status_q;
   reg wel_q;
   reg top_bottom_select_q;
   reg alt_table_q;
   reg [CNT_W-1:0] blocked_cnt_q;
   reg [7:0] last_op_q;
   reg last_granted_q;

   wire [3:0] prot_code;
   wire status_write_disable;
   wire quad_en;
   assign prot_code = status_q[`ST_CODE_MSB:`ST_CODE_LSB]; // see R10
   assign status_write_disable = status_q[`ST_WR_DISABLE];
   assign quad_en = status_q[`ST_QUAD];

   // protected range
   wire [BLK_W-1:0] range_lo;
   wire [BLK_W-1:0] range_hi;
   wire range_none;
   prot_range_decode #(
      .BLK_W(BLK_W)
   ) u_range (
      .code(prot_code),
      .bottom(top_bottom_select_q), // see R15
      .alt_table(alt_table_q),
      .lo(range_lo),
      .hi(range_hi),
      .none(range_none)
   );

   wire [BLK_W-1:0] target_blk;
   wire in_range;
   assign target_blk = cmd_addr[`BLK_LSB+BLK_W-1:`BLK_LSB]; // see R17
   assign in_range = !range_none && target_blk >= range_lo &&
      target_blk <= range_hi; // see R17

   // opcode classes
   reg is_wr_enable;
   reg is_nowel;
   reg is_welreq;
   reg is_prog_erase;
   reg is_chip;
   reg is_sr;
   always @* begin
      is_wr_enable = (cmd_opcode == `OP_WR_ENABLE);
      is_nowel = (cmd_opcode == `OP_VRP_NOWEL) ||
         (cmd_opcode == `OP_VBA_NOWEL); // see R1
      is_welreq = (cmd_opcode == `OP_VRP_WEL) ||
         (cmd_opcode == `OP_VBA_WEL);
      is_chip = (cmd_opcode == `OP_CE_A) || (cmd_opcode == `OP_CE_B);
      is_sr = (cmd_opcode == `OP_SR_WRITE);
      is_prog_erase = (cmd_opcode == `OP_PP) ||
         (cmd_opcode == `OP_PP4) ||
         (cmd_opcode == `OP_PPQ_A) ||
         (cmd_opcode == `OP_PPQ_B) ||
         (cmd_opcode == `OP_PPQ4_A) ||
         (cmd_opcode == `OP_PPQ4_B) ||
         (cmd_opcode == `OP_SE_A) ||
         (cmd_opcode == `OP_SE_B) ||
         (cmd_opcode == `OP_SE4) ||
         (cmd_opcode == `OP_BE32) ||
         (cmd_opcode == `OP_BE32_4) ||
         (cmd_opcode == `OP_BE64) ||
         (cmd_opcode == `OP_BE64_4);
   end

   // protect pin only counts while the pin is in its control role
   wire wp_level;
   wire sr_locked;
   assign wp_level = quad_en ? 1'b1 : quad_data_line_c_in; // see R7
   assign sr_locked = status_write_disable && !wp_level; // see R4 R5 R6

   // verdict
   reg grant;
   reg consume_wel;
   always @* begin
      grant = 1'b1;
      consume_wel = 1'b0;
      if (is_wr_enable || is_nowel) begin
         grant = 1'b1; // see R1
      end else if (is_prog_erase) begin
         grant = wel_q && !in_range; // see R2
         consume_wel = grant;
      end else if (is_chip) begin
         grant = wel_q && (prot_code == 4'h0); // see R3
         consume_wel = grant;
      end else if (is_sr) begin
         grant = wel_q && !sr_locked; // see R5
         consume_wel = grant;
      end else if (is_welreq) begin
         grant = wel_q;
         consume_wel = grant;
      end
   end

   // command-side state
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= `STATUS_RESET;
         wel_q <= 1'b0;
         cmd_done <= 1'b0;
         cmd_granted <= 1'b0;
         cmd_blocked <= 1'b0;
         blocked_cnt_q <= {CNT_W{1'b0}};
         last_op_q <= 8'h00;
         last_granted_q <= 1'b0;
      end else begin
         cmd_done <= cmd_valid;
         cmd_granted <= cmd_valid && grant;
         cmd_blocked <= cmd_valid && !grant;
         if (cmd_valid) begin
            last_op_q <= cmd_opcode;
            last_granted_q <= grant;
            if (is_wr_enable) begin
               wel_q <= 1'b1;
            end else if (consume_wel) begin
               wel_q <= 1'b0;
            end
            if (is_sr && grant) begin
               status_q <= cmd_status_data[7:2]; // see R6
            end
            // saturate so software never sees a wrap to zero
            if (!grant && blocked_cnt_q != {CNT_W{1'b1}}) begin
               blocked_cnt_q <= blocked_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // shared pin steering; one cycle of latency on every path
   always @(posedge aclk) begin
      if (!aresetn) begin
         quad_data_line_c_out <= 1'b0;
         quad_data_line_c_oe <= 1'b0;
         quad_data_line_d_out <= 1'b0;
         quad_data_line_d_oe <= 1'b0;
         core_c_in <= 1'b0;
         core_d_in <= 1'b0;
         hold_n <= 1'b1;
         quad_enable <= 1'b0;
      end else begin
         quad_enable <= quad_en;
         if (quad_en) begin
            quad_data_line_c_out <= core_c_out; // see R8
            quad_data_line_c_oe <= core_c_oe;
            quad_data_line_d_out <= core_d_out;
            quad_data_line_d_oe <= core_d_oe;
            core_c_in <= quad_data_line_c_in;
            core_d_in <= quad_data_line_d_in;
            hold_n <= 1'b1;
         end else begin
            // control role: pins are inputs only
            quad_data_line_c_out <= 1'b0; // see R7
            quad_data_line_c_oe <= 1'b0;
            quad_data_line_d_out <= 1'b0;
            quad_data_line_d_oe <= 1'b0;
            core_c_in <= 1'b0;
            core_d_in <= 1'b0;
            hold_n <= quad_data_line_d_in;
         end
      end
   end

   // axi write channel: address and data taken in either order
   reg aw_held_q;
   reg w_held_q;
   reg [3:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire do_write;
   assign do_write = aw_held_q && w_held_q && !bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            if (aw_addr_q == `ADDR_STATUS || aw_addr_q == `ADDR_CONFIG ||
                aw_addr_q == `ADDR_RANGE || aw_addr_q == `ADDR_EVENTS) begin
               bresp <= `RESP_OKAY;
            end else begin
               bresp <= `RESP_SLVERR;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // config register; the anchor bit can only be set, like its fuse
   always @(posedge aclk) begin
      if (!aresetn) begin
         {alt_table_q, top_bottom_select_q} <= `CONFIG_RESET;
      end else if (do_write && aw_addr_q == `ADDR_CONFIG && w_strb_q[0]) begin
         if (w_data_q[`CFG_BOTTOM]) begin
            top_bottom_select_q <= 1'b1; // see R15
         end
         alt_table_q <= w_data_q[`CFG_ALT];
      end
   end

   // axi read channel
   reg [31:0] rd_word;
   reg rd_hit;
   always @* begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      if (araddr == `ADDR_STATUS) begin
         rd_word[7:2] = status_q;
         rd_word[`ST_WEL] = wel_q;
      end else if (araddr == `ADDR_CONFIG) begin
         rd_word[`CFG_BOTTOM] = top_bottom_select_q;
         rd_word[`CFG_ALT] = alt_table_q;
      end else if (araddr == `ADDR_RANGE) begin
         rd_word[7:0] = range_lo;
         rd_word[15:8] = range_hi;
         rd_word[16] = range_none;
      end else if (araddr == `ADDR_EVENTS) begin
         rd_word[7:0] = blocked_cnt_q;
         rd_word[15:8] = last_op_q;
         rd_word[16] = last_granted_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== tb/flash_wp_checker.sv ====
// protocol and verdict assertions for the block write-protect gate
`timescale 1ns/1ps
`default_nettype none
module flash_wp_checker (
   // clock, reset and bus handshakes
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   // command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire logic [7:0] cmd_status_data,
   input wire logic cmd_done,
   input wire logic cmd_granted,
   input wire logic cmd_blocked,
   // shared pins
   input wire logic quad_data_line_c_in,
   input wire logic quad_data_line_d_in,
   input wire logic quad_data_line_c_oe,
   input wire logic quad_data_line_d_oe,
   input wire logic hold_n,
   input wire logic quad_enable
);
   logic wr_q;
   logic [7:0] sd_q;
   logic [7:0] st_q;
   logic [7:0] st_now;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // shadow of the status byte, one cycle behind the real one
   always @(posedge aclk) begin
      wr_q <= cmd_valid && cmd_opcode == 8'h01;
      sd_q <= cmd_status_data;
      if (!aresetn)
         st_q <= 8'h00;
      else if (wr_q && cmd_granted)
         st_q <= sd_q;
   end
   // a write granted last cycle is already live, even back to back
   assign st_now = (wr_q && cmd_granted) ? sd_q : st_q;
   a_nowel_grant: assert property (cmd_valid &&
      (cmd_opcode == 8'hc0 || cmd_opcode == 8'h17) |=> cmd_granted)
      else $error("volatile write refused");
   a_one_verdict: assert property (cmd_done |->
      cmd_granted != cmd_blocked) else $error("verdict not unique");
   a_done_follows: assert property (cmd_done == $past(cmd_valid))
      else $error("done not one cycle after command");
   a_chip_locked: assert property (cmd_valid && st_now[5:2] != 4'h0 &&
      (cmd_opcode == 8'hc7 || cmd_opcode == 8'h60) |=> cmd_blocked)
      else $error("chip erase passed with protection");
   a_status_lock: assert property (cmd_valid && cmd_opcode == 8'h01 &&
      st_now[7] && !st_now[6] && !quad_data_line_c_in |=> cmd_blocked)
      else $error("locked status write passed");
   a_hold_ctrl: assert property (!quad_enable && !$past(quad_enable) &&
      $past(aresetn) |-> hold_n == $past(quad_data_line_d_in) &&
      !quad_data_line_c_oe && !quad_data_line_d_oe)
      else $error("control pin roles wrong");
   a_quad_hold: assert property (quad_enable && $past(quad_enable)
      |-> hold_n) else $error("hold active in quad mode");
   a_read_ans: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_ans: assert property (awvalid && awready && wvalid && wready
      |-> ##[1:2] bvalid) else $error("write answer late");
   cover property (cmd_done && cmd_blocked);
   cover property (quad_enable && quad_data_line_c_oe);
   cover property (bvalid && bresp == 2'h2);
endmodule
bind flash_block_write_protect flash_wp_checker flash_wp_checker_i (.*);
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// host-side command source for the write-protect gate
`timescale 1ns/1ps
`default_nettype none
`include "flash_wp_defines.vh"
module spi_host_model (
   // clock
   input wire logic aclk,
   // command out
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output logic [23:0] cmd_addr,
   output logic [7:0] cmd_status_data,
   // verdict in
   input wire logic cmd_granted,
   input wire logic cmd_blocked
);
   initial begin
      cmd_valid = 1'b0;
      cmd_opcode = 8'hff;
      cmd_addr = 24'h0;
      cmd_status_data = 8'h0;
   end
   task automatic send_one(input logic [7:0] op, input logic [23:0] a,
      input logic [7:0] d, output logic [1:0] v);
      @(posedge aclk);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      cmd_addr <= a;
      cmd_status_data <= d;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      // released lines carry junk, never the old command
      cmd_opcode <= ~op;
      cmd_addr <= ~a;
      cmd_status_data <= ~d;
      #1 v = {cmd_granted, cmd_blocked};
   endtask
   task automatic send(input logic [7:0] op, input logic [23:0] a,
      input logic [7:0] d, input bit we, output logic [1:0] v);
      if (we)
         send_one(`OP_WR_ENABLE, 24'h0, 8'h0, v);
      send_one(op, a, d, v);
   endtask
endmodule
`default_nettype wire

// ==== tb/flash_block_write_protect_tb.sv ====
// self-checking bench for the block write-protect gate
`timescale 1ns/1ps
`default_nettype none
`include "flash_wp_defines.vh"
module flash_block_write_protect_tb;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic cmd_valid, cmd_done, cmd_granted, cmd_blocked;
   logic [7:0] cmd_opcode, cmd_status_data;
   logic [23:0] cmd_addr;
   logic c_out, c_oe, d_out, d_oe, core_c_in, core_d_in, hold_n, qe;
   logic c_lvl = 1'b1, d_lvl = 1'b1, cc_out = 1'b0, cc_oe = 1'b0;
   wire c_pin = c_oe ? c_out : c_lvl;
   wire d_pin = d_oe ? d_out : d_lvl;
   int err_total = 0, check_count = 0;
   logic [7:0] ops [13] = '{`OP_PP, `OP_PP4, `OP_PPQ_A, `OP_PPQ_B,
      `OP_PPQ4_A, `OP_PPQ4_B, `OP_SE_A, `OP_SE_B, `OP_SE4, `OP_BE32,
      `OP_BE32_4, `OP_BE64, `OP_BE64_4};
   flash_block_write_protect flash_block_write_protect_i (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
      .cmd_addr(cmd_addr), .cmd_status_data(cmd_status_data),
      .cmd_done(cmd_done), .cmd_granted(cmd_granted),
      .cmd_blocked(cmd_blocked), .quad_data_line_c_in(c_pin),
      .quad_data_line_c_out(c_out), .quad_data_line_c_oe(c_oe),
      .quad_data_line_d_in(d_pin), .quad_data_line_d_out(d_out),
      .quad_data_line_d_oe(d_oe), .core_c_out(cc_out), .core_c_oe(cc_oe),
      .core_d_out(cc_out), .core_d_oe(cc_oe), .core_c_in(core_c_in),
      .core_d_in(core_d_in), .hold_n(hold_n), .quad_enable(qe));
   spi_host_model spi_host_model_i (.aclk(aclk), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
      .cmd_status_data(cmd_status_data), .cmd_granted(cmd_granted),
      .cmd_blocked(cmd_blocked));
   initial begin
      forever #50 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
      bit aw = 0, w = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (1) begin
         @(posedge aclk);
         if (bvalid) break;
         if (awready && !aw) awvalid <= 1'b0;
         if (wready && !w) wvalid <= 1'b0;
         aw = aw | awready;
         w = w | wready;
      end
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (1) begin
         @(posedge aclk);
         if (rvalid) break;
         if (arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      chk("rresp", 32'(rresp), 32'(er));
      chk("rdata", rdata, ed);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
      input logic [7:0] d, input bit we, input logic [1:0] e);
      logic [1:0] v;
      spi_host_model_i.send(op, a, d, we, v);
      chk("verdict", 32'(v), 32'(e));
   endtask
   function automatic int blocks(input int c, input bit alt);
      if (c == 0) return 0;
      if (c <= 8) return 1 << (c - 1);
      if (alt && c < 15) return 256 - (1 << (15 - c));
      return 256;
   endfunction
   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #2000000;
      err_total++;
      finish_test;
   end
   initial begin
      int n, b;
      logic [31:0] cfg;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
      axi_rd(4'h2, 32'h0, `RESP_SLVERR);
      axi_wr(4'h2, 32'h1, `RESP_SLVERR);
      cmd(`OP_VRP_NOWEL, 0, 0, 0, 2'b10);
      cmd(`OP_VBA_NOWEL, 0, 0, 0, 2'b10);
      cmd(`OP_VRP_WEL, 0, 0, 0, 2'b01);
      cmd(`OP_PP, 0, 0, 0, 2'b01);
      axi_rd(`ADDR_EVENTS, 32'h0202, `RESP_OKAY);
      @(posedge aclk) c_lvl <= 1'b0;
      cmd(`OP_SR_WRITE, 0, 8'h04, 1, 2'b10);
      cmd(`OP_SR_WRITE, 0, 8'h80, 1, 2'b10);
      cmd(`OP_SR_WRITE, 0, 8'h00, 1, 2'b01);
      axi_rd(`ADDR_STATUS, 32'h82, `RESP_OKAY);
      @(posedge aclk) c_lvl <= 1'b1;
      cmd(`OP_SR_WRITE, 0, 8'h00, 0, 2'b10);
      axi_rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
      @(posedge aclk) d_lvl <= 1'b0;
      cc_out <= 1'b1;
      cc_oe <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("hold", 32'(hold_n), 0);
      chk("pins", 32'({c_oe, d_oe, core_c_in, core_d_in}), 0);
      d_lvl <= 1'b1;
      cmd(`OP_SR_WRITE, 0, 8'h40, 1, 2'b10);
      repeat (3) @(posedge aclk);
      chk("quad", 32'({hold_n, c_oe, c_out, d_oe, d_out, core_d_in}),
         32'h3f);
      cmd(`OP_SR_WRITE, 0, 8'h00, 1, 2'b10);
      for (int k = 0; k < 4; k++) begin
         cfg = {30'h0, k[0], k[1]};
         axi_wr(`ADDR_CONFIG, cfg, `RESP_OKAY);
         axi_rd(`ADDR_CONFIG, cfg, `RESP_OKAY);
         for (int c = 0; c < 16; c++) begin
            n = blocks(c, k[0]);
            cmd(`OP_SR_WRITE, 0, 8'(c << 2), 1, 2'b10);
            b = k[1] ? n - 1 : 256 - n;
            if (n > 0) begin
               axi_rd(`ADDR_RANGE, k[1] ? 32'(n - 1) << 8 :
                  32'hff00 | 32'(256 - n), `RESP_OKAY);
               cmd(ops[c % 13], {b[7:0], 16'hffff}, 0, 1, 2'b01);
            end
            b = k[1] ? n : 255 - n;
            if (n < 256)
               cmd(ops[(c + 6) % 13], {b[7:0], 16'h0}, 0, 1, 2'b10);
            cmd(c[0] ? `OP_CE_A : `OP_CE_B, 0, 0, 1,
               c == 0 ? 2'b10 : 2'b01);
         end
      end
      axi_wr(`ADDR_CONFIG, 32'h0, `RESP_OKAY);
      axi_rd(`ADDR_CONFIG, 32'h1, `RESP_OKAY);
      finish_test;
   end
endmodule
`default_nettype wire
